// ### verilog/ctm_mode_control.sv
`timescale 1ns/1ps
`include "ctm_regs.svh"

module ctm_mode_control (
  input wire logic clk,
  input wire logic reset_n,
  input wire ctm_pkg::ctm_sbc_t sbcMode,
  input wire ctm_pkg::ctm_cmd_t modeCmd,
  input wire logic [15:0] enableCycles,
  input wire logic busTxDataIn,
  input wire logic busRxLevel,
  output logic busDriveDominant,
  output logic busRxDataOut,
  output ctm_pkg::ctm_mode_t modeStatus,
  output logic enableDone,
  output logic wakeEvent,
  output logic busWoken
);

  localparam ctm_pkg::ctm_top_st_t RESET_ST = '{
    txSync: `CTM_SYNC_RESET,
    txLevel: 1'b1,
    rxSync: `CTM_SYNC_RESET,
    rxLevel: 1'b1,
    mode: ctm_pkg::CTM_MODE_OFF,
    sbcPrev: ctm_pkg::CTM_SBC_NORMAL,
    enCnt: 16'h0000,
    enDone: 1'b0,
    txArmed: 1'b0,
    woken: 1'b0,
    wake: 1'b0,
    drive: 1'b0,
    rxOut: 1'b1
  };

  ctm_pkg::ctm_top_st_t q;
  ctm_pkg::ctm_top_st_t d;
  logic wakeHit;
  logic wakeArm;
  logic sbcEntered;

  // ==================================================================
  // Mode legality
  // Wake Capable is listed for every host mode because fail-safe enters it
  // on its own; the command path shares the same check.
  function automatic logic modeAllowed(input ctm_pkg::ctm_mode_t m,
                                       input ctm_pkg::ctm_sbc_t s);
    logic ok;
    ok = 1'b0;
    case (m)
      ctm_pkg::CTM_MODE_OFF: begin
        ok = 1'b1;
      end
      ctm_pkg::CTM_MODE_WAKE: begin
        ok = 1'b1;
      end
      ctm_pkg::CTM_MODE_RXONLY: begin
        ok = (s == ctm_pkg::CTM_SBC_NORMAL) || (s == ctm_pkg::CTM_SBC_STOP);
      end
      ctm_pkg::CTM_MODE_NORMAL: begin
        ok = (s == ctm_pkg::CTM_SBC_NORMAL);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  assign sbcEntered = (sbcMode != q.sbcPrev);
  assign wakeArm = (q.mode == ctm_pkg::CTM_MODE_WAKE) && !q.woken;

  ctm_wake_detect u_wake (
    .clk(clk),
    .reset_n(reset_n),
    .arm(wakeArm),
    .busLevel(q.rxLevel),
    .hit(wakeHit)
  );

  // ==================================================================
  // Next state
  always_comb begin
    d = q;
    // Pin inputs pass three stages; a level counts once stages two and three agree.
    d.txSync = {q.txSync[1:0], busTxDataIn};
    d.rxSync = {q.rxSync[1:0], busRxLevel};
    if (q.txSync[1] == q.txSync[2]) begin
      d.txLevel = q.txSync[2];
    end
    if (q.rxSync[1] == q.rxSync[2]) begin
      d.rxLevel = q.rxSync[2];
    end
    d.sbcPrev = sbcMode;

    if (q.mode == ctm_pkg::CTM_MODE_NORMAL && !q.enDone) begin
      if (q.enCnt <= 16'h0001) begin
        d.enDone = 1'b1;
      end
      if (q.enCnt != 16'h0000) begin
        d.enCnt = q.enCnt - 16'h0001;
      end
    end

    // Arming needs a recessive level after the wait, so a dominant held
    // across the end of the wait is never cut into a short bit.
    if (q.mode == ctm_pkg::CTM_MODE_NORMAL && q.enDone && q.txLevel) begin
      d.txArmed = 1'b1;
    end

    if (modeCmd.valid && modeAllowed(modeCmd.mode, sbcMode)) begin
      d.mode = modeCmd.mode;
      if (modeCmd.mode == ctm_pkg::CTM_MODE_NORMAL && q.mode != ctm_pkg::CTM_MODE_NORMAL) begin
        d.enCnt = enableCycles;
        d.enDone = (enableCycles == 16'h0000);
        d.txArmed = 1'b0;
      end
      if (modeCmd.mode != q.mode) begin
        d.woken = 1'b0;
      end
    end

    if (sbcEntered && sbcMode == ctm_pkg::CTM_SBC_FAILSAFE) begin
      d.mode = ctm_pkg::CTM_MODE_WAKE;
    end
    if (!modeAllowed(d.mode, sbcMode)) begin
      d.mode = ctm_pkg::CTM_MODE_WAKE;
    end

    // Entering a low-power or fail-safe host mode re-arms wake detection.
    if (sbcEntered && (sbcMode == ctm_pkg::CTM_SBC_STOP || sbcMode == ctm_pkg::CTM_SBC_SLEEP
                       || sbcMode == ctm_pkg::CTM_SBC_FAILSAFE)) begin
      d.woken = 1'b0;
    end

    if (d.mode != ctm_pkg::CTM_MODE_NORMAL) begin
      d.enDone = 1'b0;
      d.txArmed = 1'b0;
      d.enCnt = 16'h0000;
    end

    // Detections only arrive while armed in Wake Capable, so Off ignores them.
    d.wake = wakeHit && wakeArm;
    if (d.wake && d.mode == ctm_pkg::CTM_MODE_WAKE) begin
      d.woken = 1'b1;
    end
    if (d.mode != ctm_pkg::CTM_MODE_WAKE) begin
      d.woken = 1'b0;
    end

    // Latency is a few 4 ns cycles, far below a 500 ns bit at the top rate.
    d.drive = (q.mode == ctm_pkg::CTM_MODE_NORMAL) && q.txArmed && !q.txLevel;

    if (q.mode == ctm_pkg::CTM_MODE_WAKE && q.woken) begin
      d.rxOut = 1'b0;
    end else if (q.mode == ctm_pkg::CTM_MODE_NORMAL || q.mode == ctm_pkg::CTM_MODE_RXONLY) begin
      d.rxOut = q.rxLevel;
    end else begin
      d.rxOut = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= RESET_ST;
    end else begin
      q <= d;
    end
  end

  assign busDriveDominant = q.drive;
  assign busRxDataOut = q.rxOut;
  assign modeStatus = q.mode;
  assign enableDone = q.enDone;
  assign wakeEvent = q.wake;
  assign busWoken = q.woken;

  // ==================================================================
  // Checks
  property p_off_after_reset;
    @(posedge clk)
    !reset_n |=> modeStatus == ctm_pkg::CTM_MODE_OFF && !busDriveDominant;
  endproperty
  a_off_after_reset: assert property (p_off_after_reset) else $error("not off after reset");

  property p_off_any_mode;
    @(posedge clk) disable iff (!reset_n)
    (modeCmd.valid && modeCmd.mode == ctm_pkg::CTM_MODE_OFF
     && !(sbcEntered && sbcMode == ctm_pkg::CTM_SBC_FAILSAFE))
    |=> modeStatus == ctm_pkg::CTM_MODE_OFF;
  endproperty
  a_off_any_mode: assert property (p_off_any_mode) else $error("off command refused");

  property p_off_no_wake;
    @(posedge clk) disable iff (!reset_n)
    modeStatus == ctm_pkg::CTM_MODE_OFF |=> !wakeEvent && !busWoken;
  endproperty
  a_off_no_wake: assert property (p_off_no_wake) else $error("wake seen in off");

  property p_normal_by_cmd;
    @(posedge clk) disable iff (!reset_n)
    $rose(modeStatus == ctm_pkg::CTM_MODE_NORMAL)
    |-> $past(modeCmd.valid && modeCmd.mode == ctm_pkg::CTM_MODE_NORMAL);
  endproperty
  a_normal_by_cmd: assert property (p_normal_by_cmd) else $error("normal without cmd");

  property p_normal_host;
    @(posedge clk) disable iff (!reset_n)
    modeStatus == ctm_pkg::CTM_MODE_NORMAL |-> $past(sbcMode) == ctm_pkg::CTM_SBC_NORMAL;
  endproperty
  a_normal_host: assert property (p_normal_host) else $error("normal outside host normal");

  property p_drive_follows;
    @(posedge clk) disable iff (!reset_n)
    busDriveDominant |-> $past(!q.txLevel && modeStatus == ctm_pkg::CTM_MODE_NORMAL);
  endproperty
  a_drive_follows: assert property (p_drive_follows) else $error("drive not from input");

  property p_enable_wait;
    @(posedge clk) disable iff (!reset_n)
    (modeCmd.valid && modeCmd.mode == ctm_pkg::CTM_MODE_NORMAL && enableCycles == 16'h0003
     && modeStatus != ctm_pkg::CTM_MODE_NORMAL && sbcMode == ctm_pkg::CTM_SBC_NORMAL
     && !sbcEntered)
    |=> (!enableDone && !busDriveDominant)[*3] ##1 enableDone;
  endproperty
  a_enable_wait: assert property (p_enable_wait) else $error("enabling time wrong");

  property p_first_dom_after;
    @(posedge clk) disable iff (!reset_n)
    $rose(busDriveDominant) |-> $past(q.txArmed) && $past(enableDone, 2);
  endproperty
  a_first_dom_after: assert property (p_first_dom_after) else $error("early dominant");

  property p_arm_needs_rec;
    @(posedge clk) disable iff (!reset_n)
    $rose(q.txArmed) |-> $past(q.enDone && q.txLevel);
  endproperty
  a_arm_needs_rec: assert property (p_arm_needs_rec) else $error("armed without recessive");

  property p_rx_follows;
    @(posedge clk) disable iff (!reset_n)
    $past(modeStatus == ctm_pkg::CTM_MODE_NORMAL || modeStatus == ctm_pkg::CTM_MODE_RXONLY)
    |-> busRxDataOut == $past(q.rxLevel);
  endproperty
  a_rx_follows: assert property (p_rx_follows) else $error("receive output stale");

  property p_rxonly_silent;
    @(posedge clk) disable iff (!reset_n)
    modeStatus == ctm_pkg::CTM_MODE_RXONLY |=> !busDriveDominant;
  endproperty
  a_rxonly_silent: assert property (p_rxonly_silent) else $error("drive in rx only");

  property p_wake_sets;
    @(posedge clk) disable iff (!reset_n)
    wakeEvent && modeStatus == ctm_pkg::CTM_MODE_WAKE |-> busWoken;
  endproperty
  a_wake_sets: assert property (p_wake_sets) else $error("wake not latched");

  property p_woken_rx_low;
    @(posedge clk) disable iff (!reset_n)
    busWoken && modeStatus == ctm_pkg::CTM_MODE_WAKE |=> !busRxDataOut;
  endproperty
  a_woken_rx_low: assert property (p_woken_rx_low) else $error("rx not low after wake");

  property p_woken_mode;
    @(posedge clk) disable iff (!reset_n)
    busWoken |-> modeStatus == ctm_pkg::CTM_MODE_WAKE;
  endproperty
  a_woken_mode: assert property (p_woken_mode) else $error("woken outside wake mode");

  property p_rxonly_host;
    @(posedge clk) disable iff (!reset_n)
    $rose(modeStatus == ctm_pkg::CTM_MODE_RXONLY)
    |-> $past(sbcMode) == ctm_pkg::CTM_SBC_NORMAL || $past(sbcMode) == ctm_pkg::CTM_SBC_STOP;
  endproperty
  a_rxonly_host: assert property (p_rxonly_host) else $error("rx only in wrong host mode");

  property p_tx_latency;
    @(posedge clk) disable iff (!reset_n)
    (modeStatus == ctm_pkg::CTM_MODE_NORMAL && q.txArmed && !busTxDataIn)[*6]
    |-> busDriveDominant;
  endproperty
  a_tx_latency: assert property (p_tx_latency) else $error("transmit path too slow");

endmodule

// ### include/ctm_regs.svh
// Contract
// - Start in Off mode after power-up.
// - Off selectable in every host mode.
// - Bus wake activity ignored while Off.
// - Normal entered only by serial command.
// - Normal allowed only in host Normal.
// - Driver dominant while transmit input low.
// - Wait enabling time before passing dominant.
// - Only first dominant after enabling transmitted.
// - Bus level presented on receive output.
// - Receive-only mode suppresses transmission.
// - Bus message in Wake Capable raises wake.
// - Path carries data up to 2Mbaud.
// - After wake, receive output low until change.
// - Mode reads Wake Capable 01 after wake.
// - Receive-only only in host Normal or Stop.
// - Wake pattern: two timed dominants, timed gap.
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// ====================================================================
// Timing
`define CTM_CLK_MHZ 250
`define CTM_MAX_BAUD 2000000
`define CTM_T_WAKE1_NS 500
`define CTM_T_WAKE2_NS 5000
`define CTM_WAKE1_CYC ((`CTM_T_WAKE1_NS * `CTM_CLK_MHZ + 999) / 1000)
`define CTM_WAKE2_CYC ((`CTM_T_WAKE2_NS * `CTM_CLK_MHZ) / 1000)

// ====================================================================
// Widths and reset values
`define CTM_WAKE_CNT_W 12
`define CTM_EN_CNT_W 16
`define CTM_SYNC_RESET 3'h7

`endif

// ### include/ctm_pkg.sv
package ctm_pkg;

  // ==================================================================
  // Modes and states
  typedef enum logic [1:0] {
    CTM_MODE_OFF = 2'b00,
    CTM_MODE_WAKE = 2'b01,
    CTM_MODE_RXONLY = 2'b10,
    CTM_MODE_NORMAL = 2'b11
  } ctm_mode_t;

  typedef enum logic [2:0] {
    CTM_SBC_NORMAL = 3'b000,
    CTM_SBC_STOP = 3'b001,
    CTM_SBC_SLEEP = 3'b010,
    CTM_SBC_RESTART = 3'b011,
    CTM_SBC_FAILSAFE = 3'b100
  } ctm_sbc_t;

  typedef enum logic [1:0] {
    CTM_WK_IDLE = 2'b00,
    CTM_WK_DOM1 = 2'b01,
    CTM_WK_REC = 2'b10,
    CTM_WK_DOM2 = 2'b11
  } ctm_wstate_t;

  // ==================================================================
  // Carriers and state records
  typedef struct packed {
    logic valid;
    ctm_mode_t mode;
  } ctm_cmd_t;

  typedef struct packed {
    ctm_wstate_t st;
    logic [11:0] cnt;
    logic prevLevel;
    logic hit;
  } ctm_wk_st_t;

  typedef struct packed {
    logic [2:0] txSync;
    logic txLevel;
    logic [2:0] rxSync;
    logic rxLevel;
    ctm_mode_t mode;
    ctm_sbc_t sbcPrev;
    logic [15:0] enCnt;
    logic enDone;
    logic txArmed;
    logic woken;
    logic wake;
    logic drive;
    logic rxOut;
  } ctm_top_st_t;

endpackage

// ### verilog/ctm_wake_detect.sv
`timescale 1ns/1ps
`include "ctm_regs.svh"

module ctm_wake_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic arm,
  input wire logic busLevel,
  output logic hit
);

  localparam logic [11:0] W1 = 12'(`CTM_WAKE1_CYC);
  localparam logic [11:0] W2 = 12'(`CTM_WAKE2_CYC);

  ctm_pkg::ctm_wk_st_t q;
  ctm_pkg::ctm_wk_st_t d;
  logic phaseOk;

  assign hit = q.hit;
  assign phaseOk = (q.cnt >= W1) && (q.cnt < W2);

  // ==================================================================
  // Pattern tracking
  // A phase length is judged at the edge that ends it; the second dominant
  // fires as soon as it reaches the minimum, so no trailing edge is needed.
  always_comb begin
    d = q;
    d.hit = 1'b0;
    d.prevLevel = busLevel;
    if (!arm) begin
      d.st = ctm_pkg::CTM_WK_IDLE;
      d.cnt = 12'h001;
    end else if (busLevel != q.prevLevel) begin
      d.cnt = 12'h001;
      case (q.st)
        ctm_pkg::CTM_WK_IDLE: begin
          d.st = busLevel ? ctm_pkg::CTM_WK_IDLE : ctm_pkg::CTM_WK_DOM1;
        end
        ctm_pkg::CTM_WK_DOM1: begin
          d.st = phaseOk ? ctm_pkg::CTM_WK_REC : ctm_pkg::CTM_WK_IDLE;
        end
        ctm_pkg::CTM_WK_REC: begin
          d.st = phaseOk ? ctm_pkg::CTM_WK_DOM2 : ctm_pkg::CTM_WK_DOM1;
        end
        default: begin
          d.st = ctm_pkg::CTM_WK_IDLE;
        end
      endcase
    end else begin
      if (q.cnt != 12'hfff) begin
        d.cnt = q.cnt + 12'h001;
      end
      if (q.st == ctm_pkg::CTM_WK_DOM2 && q.cnt == W1 - 12'h001) begin
        d.hit = 1'b1;
        d.st = ctm_pkg::CTM_WK_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{st: ctm_pkg::CTM_WK_IDLE, cnt: 12'h001, prevLevel: 1'b1, hit: 1'b0};
    end else begin
      q <= d;
    end
  end

  property p_hit_from_dom2;
    @(posedge clk) disable iff (!reset_n)
    hit |-> $past(q.st) == ctm_pkg::CTM_WK_DOM2 && !$past(busLevel);
  endproperty
  a_hit_from_dom2: assert property (p_hit_from_dom2) else $error("wake without pattern");

endmodule

// ### tb/ctm_ctrl_model.sv
`timescale 1ns/1ps

// ====================================================================
// Protocol controller model: idles recessive and shifts a byte out MSB first.
module ctm_ctrl_model #(
  parameter int BIT_CYC = 125
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic early,
  input wire logic sendReq,
  input wire logic [7:0] sendByte,
  output logic txPin
);
  logic [7:0] shiftQ;
  logic [3:0] leftQ;
  int cntQ;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      leftQ <= 4'h0;
      cntQ <= 0;
      shiftQ <= 8'hff;
    end else if (sendReq && leftQ == 4'h0) begin
      shiftQ <= sendByte;
      leftQ <= 4'h8;
      cntQ <= 0;
    end else if (leftQ != 4'h0) begin
      if (cntQ == BIT_CYC - 1) begin
        cntQ <= 0;
        leftQ <= leftQ - 4'h1;
        shiftQ <= {shiftQ[6:0], 1'b1};
      end else begin
        cntQ <= cntQ + 1;
      end
    end
  end

  // The early input breaks the recessive hold on purpose for one scenario.
  assign txPin = early ? 1'b0 : (leftQ != 4'h0 ? shiftQ[7] : 1'b1);
endmodule

// ### tb/ctm_mode_control_tb.sv
`timescale 1ns/1ps

module ctm_mode_control_tb;
  localparam int BIT_CYC = 125;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ctm_pkg::ctm_sbc_t sbcMode = ctm_pkg::CTM_SBC_NORMAL;
  ctm_pkg::ctm_cmd_t modeCmd = '0;
  logic [15:0] enableCycles = 16'h0010;
  logic busOther = 1'b1;
  logic early = 1'b0;
  logic sendReq = 1'b0;
  logic [7:0] sendByte = 8'h00;
  logic busTx, drive, rxOut, done, wakeEv, woken, busLevel;
  ctm_pkg::ctm_mode_t modeStatus;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int wakes = 0;
  logic [3:0] qKind[$];
  logic [3:0] qVal[$];
  logic [3:0] k, v;
  event probe;

  // The bus is recessive unless our driver or another node pulls it dominant.
  assign busLevel = busOther & ~drive;
  always #2 clk = ~clk;

  ctm_ctrl_model #(.BIT_CYC(BIT_CYC)) ctm_ctrl_model_inst (.clk(clk), .reset_n(reset_n),
    .early(early), .sendReq(sendReq), .sendByte(sendByte), .txPin(busTx));

  ctm_mode_control ctm_mode_control_inst (.clk(clk), .reset_n(reset_n), .sbcMode(sbcMode),
    .modeCmd(modeCmd), .enableCycles(enableCycles), .busTxDataIn(busTx),
    .busRxLevel(busLevel), .busDriveDominant(drive), .busRxDataOut(rxOut),
    .modeStatus(modeStatus), .enableDone(done), .wakeEvent(wakeEv), .busWoken(woken));

  // ==================================================================
  // Scoreboard
  function automatic logic [3:0] actual(input logic [3:0] kind);
    case (kind)
      4'h0: return {2'b00, modeStatus};
      4'h1: return {3'b000, drive};
      4'h2: return {3'b000, rxOut};
      4'h3: return {3'b000, done};
      4'h4: return {3'b000, woken};
      default: return wakes[3:0];
    endcase
  endfunction

  always begin
    @(probe);
    while (qKind.size() > 0) begin
      k = qKind.pop_front();
      v = qVal.pop_front();
      n_checks++;
      if (actual(k) !== v) begin
        n_mismatch++;
        $display("FAIL t=%0t kind %0h exp %0h got %0h", $time, k, v, actual(k));
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wakeEv === 1'b1) begin
      wakes <= wakes + 1;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==================================================================
  // Drivers
  task automatic note(input logic [3:0] kind, input logic [3:0] val);
    qKind.push_back(kind);
    qVal.push_back(val);
    ->probe;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input ctm_pkg::ctm_mode_t m);
    modeCmd = '{1'b1, m};
    tick(1);
    modeCmd = '0;
    tick(1);
  endtask

  function automatic logic legal(input ctm_pkg::ctm_sbc_t s, input ctm_pkg::ctm_mode_t m);
    return m == ctm_pkg::CTM_MODE_OFF || m == ctm_pkg::CTM_MODE_WAKE
      || (m == ctm_pkg::CTM_MODE_RXONLY && (s == ctm_pkg::CTM_SBC_NORMAL
      || s == ctm_pkg::CTM_SBC_STOP))
      || (m == ctm_pkg::CTM_MODE_NORMAL && s == ctm_pkg::CTM_SBC_NORMAL);
  endfunction

  task automatic wake_pattern(input int d1, input int r, input int d2);
    busOther = 1'b0;
    tick(d1);
    busOther = 1'b1;
    tick(r);
    busOther = 1'b0;
    tick(d2);
    busOther = 1'b1;
    tick(20);
  endtask

  // Samples each bit in its middle, so sync and filter latency do not matter.
  task automatic send_check(input logic txOn);
    sendByte = 8'($urandom);
    sendReq = 1'b1;
    tick(1);
    sendReq = 1'b0;
    tick(BIT_CYC / 2);
    for (int i = 0; i < 8; i++) begin
      note(4'h2, {3'b000, txOn ? sendByte[7 - i] : 1'b1});
      note(4'h1, {3'b000, txOn & ~sendByte[7 - i]});
      tick(BIT_CYC);
    end
  endtask

  initial begin
    void'($urandom(31358));
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    note(4'h0, 4'h0);
    note(4'h2, 4'h1);
    note(4'h1, 4'h0);
    for (int s = 0; s < 5; s++) begin
      sbcMode = ctm_pkg::ctm_sbc_t'(3'(s));
      tick(3);
      if (s == 4) begin
        note(4'h0, {2'b00, ctm_pkg::CTM_MODE_WAKE});
      end
      for (int m = 0; m < 4; m++) begin
        cmd(ctm_pkg::CTM_MODE_OFF);
        note(4'h0, 4'h0);
        cmd(ctm_pkg::ctm_mode_t'(2'(m)));
        note(4'h0, legal(sbcMode, ctm_pkg::ctm_mode_t'(2'(m))) ? 4'(m) : 4'h0);
      end
    end
    sbcMode = ctm_pkg::CTM_SBC_NORMAL;
    tick(3);
    cmd(ctm_pkg::CTM_MODE_OFF);
    // A short fixed wait exercises the exact cycle count at its end points.
    enableCycles = 16'h0003;
    cmd(ctm_pkg::CTM_MODE_NORMAL);
    note(4'h3, 4'h0);
    tick(2);
    note(4'h3, 4'h1);
    cmd(ctm_pkg::CTM_MODE_OFF);
    enableCycles = 16'(20 + $urandom_range(0, 40));
    early = 1'b1;
    modeCmd = '{1'b1, ctm_pkg::CTM_MODE_NORMAL};
    tick(1);
    modeCmd = '0;
    tick(int'(enableCycles) - 1);
    note(4'h3, 4'h0);
    tick(1);
    note(4'h3, 4'h1);
    tick(30);
    note(4'h1, 4'h0);
    early = 1'b0;
    tick(10);
    send_check(1'b1);
    cmd(ctm_pkg::CTM_MODE_RXONLY);
    note(4'h3, 4'h0);
    send_check(1'b0);
    busOther = 1'b0;
    tick(10);
    note(4'h2, 4'h0);
    busOther = 1'b1;
    tick(10);
    cmd(ctm_pkg::CTM_MODE_OFF);
    wake_pattern(200, 200, 200);
    note(4'h5, 4'h0);
    cmd(ctm_pkg::CTM_MODE_WAKE);
    wake_pattern(60, 200, 200);
    tick(2000);
    note(4'h5, 4'h0);
    wake_pattern(200, 200, 200);
    note(4'h5, 4'h1);
    note(4'h4, 4'h1);
    tick(300);
    note(4'h2, 4'h0);
    note(4'h0, {2'b00, ctm_pkg::CTM_MODE_WAKE});
    cmd(ctm_pkg::CTM_MODE_OFF);
    note(4'h4, 4'h0);
    note(4'h2, 4'h1);
    cmd(ctm_pkg::CTM_MODE_WAKE);
    wake_pattern(200, 200, 200);
    note(4'h5, 4'h2);
    tick(2);
    report_and_stop();
  end
endmodule
